//--- logic/rhpt_pkg.sv
// Package: command codes, field layout and power command encodings
package rhpt_pkg;

	// ---------------------------------------------------------------
	// Command codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_TRAITS_RD = 8'h13;
	localparam logic [7:0] CMD_TRAITS_WR = 8'h93;

	// ---------------------------------------------------------------
	// Field layout
	// ---------------------------------------------------------------
	localparam int MASK_LSB   = 16;
	localparam int NREM_LSB   = 0;
	localparam int FIELD_W    = 3;
	localparam int NUM_PORTS  = 2;

	// ---------------------------------------------------------------
	// Reset values (defaults of the top-level parameters)
	// ---------------------------------------------------------------
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [2:0] NREM_RESET = 3'h0;

	// ---------------------------------------------------------------
	// Power commands
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		RHPT_PWR_NONE     = 3'b000,
		RHPT_PWR_ALL_ON   = 3'b001,
		RHPT_PWR_ALL_OFF  = 3'b010,
		RHPT_PWR_PORT_ON  = 3'b011,
		RHPT_PWR_PORT_OFF = 3'b100
	} rhpt_pwr_cmd_e;

endpackage

//--- logic/rhpt_pwr_if.sv
// Interface: power command path between register bank and power logic
`timescale 1ns/1ps
interface rhpt_pwr_if;
	logic                  cmd_valid;
	rhpt_pkg::rhpt_pwr_cmd_e cmd;
	logic [1:0]            cmd_port;
	logic                  power_switch_scheme;
	logic [2:0]            per_port_power_mask;
	logic [1:0]            port_powered_flag;

	modport bank (
		output cmd_valid,
		output cmd,
		output cmd_port,
		output power_switch_scheme,
		output per_port_power_mask,
		input  port_powered_flag
	);
	modport pwr (
		input  cmd_valid,
		input  cmd,
		input  cmd_port,
		input  power_switch_scheme,
		input  per_port_power_mask,
		output port_powered_flag
	);
endinterface

//--- logic/rhpt_port_power.sv
// Port power state: applies global and per-port commands through the mask
`timescale 1ns/1ps
module rhpt_port_power (
	input  wire logic clk,
	input  wire logic rstn,
	rhpt_pwr_if.pwr   pif
);

	// ---------------------------------------------------------------
	// Port power state
	// ---------------------------------------------------------------
	logic [1:0] powered_q;
	logic [1:0] powered_d;

	always_comb begin
		powered_d = powered_q;
		if (pif.cmd_valid) begin
			for (int p = 1; p <= 2; p++) begin
				// Mask bit 0 is reserved; bit p governs port p
				if (!pif.power_switch_scheme) begin
					if (pif.cmd == rhpt_pkg::RHPT_PWR_ALL_ON)
						powered_d[p-1] = 1'b1;
					else if (pif.cmd == rhpt_pkg::RHPT_PWR_ALL_OFF)
						powered_d[p-1] = 1'b0;
				end else if (pif.per_port_power_mask[p]) begin
					if (pif.cmd == rhpt_pkg::RHPT_PWR_PORT_ON &&
					    pif.cmd_port == 2'(p))
						powered_d[p-1] = 1'b1;
					else if (pif.cmd == rhpt_pkg::RHPT_PWR_PORT_OFF &&
					         pif.cmd_port == 2'(p))
						powered_d[p-1] = 1'b0;
				end else begin
					if (pif.cmd == rhpt_pkg::RHPT_PWR_ALL_ON)
						powered_d[p-1] = 1'b1;
					else if (pif.cmd == rhpt_pkg::RHPT_PWR_ALL_OFF)
						powered_d[p-1] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			powered_q <= 2'h0;
		else
			powered_q <= powered_d;
	end

	assign pif.port_powered_flag = powered_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	masked_port_a: assert property (@(posedge clk) disable iff (!rstn)
		pif.cmd_valid && pif.power_switch_scheme &&
		pif.per_port_power_mask[1] &&
		(pif.cmd == rhpt_pkg::RHPT_PWR_ALL_ON ||
		 pif.cmd == rhpt_pkg::RHPT_PWR_ALL_OFF)
		|=> $stable(powered_q[0]))
		else $error("masked port 1 followed a global command");

	unmasked_port_a: assert property (@(posedge clk) disable iff (!rstn)
		pif.cmd_valid && pif.power_switch_scheme &&
		!pif.per_port_power_mask[2] &&
		(pif.cmd == rhpt_pkg::RHPT_PWR_PORT_ON ||
		 pif.cmd == rhpt_pkg::RHPT_PWR_PORT_OFF)
		|=> $stable(powered_q[1]))
		else $error("unmasked port 2 followed a port command");

	ganged_on_a: assert property (@(posedge clk) disable iff (!rstn)
		pif.cmd_valid && !pif.power_switch_scheme &&
		pif.cmd == rhpt_pkg::RHPT_PWR_ALL_ON
		|=> powered_q == 2'h3)
		else $error("ganged power-on missed a port");

	ganged_off_a: assert property (@(posedge clk) disable iff (!rstn)
		pif.cmd_valid && !pif.power_switch_scheme &&
		pif.cmd == rhpt_pkg::RHPT_PWR_ALL_OFF
		|=> powered_q == 2'h0)
		else $error("ganged power-off missed a port");

	global_on_a: assert property (@(posedge clk) disable iff (!rstn)
		pif.cmd_valid && pif.power_switch_scheme &&
		!pif.per_port_power_mask[1] &&
		pif.cmd == rhpt_pkg::RHPT_PWR_ALL_ON
		|=> powered_q[0])
		else $error("unmasked port 1 not set by global power-on");

endmodule

//--- logic/rhpt_traits.sv
// Root hub port traits register with port power control
//
// Function
// - Read command 0x13 and write command 0x93 reach the same register.
// - Reset values of mask and removability fields are build parameters.
// - In per-port scheme a masked port changes power only on per-port power commands.
// - Unmasked port follows global commands, ignores per-port commands.
// - Global switching scheme makes the mask ineffective.
// - Mask bit 0 reserved, bit 1 port 1, bit 2 port 2.
// - Removability field bits 2..0; set means device not removable.
// - Removability bit 0 reserved, bit 1 port 1, bit 2 port 2.
// - In global scheme all ports power on and off together.
// - Per-port scheme global power-on sets only unmasked ports.
`timescale 1ns/1ps
module rhpt_traits #(
	parameter logic [2:0] MASK_INIT = rhpt_pkg::MASK_RESET,
	parameter logic [2:0] NREM_INIT = rhpt_pkg::NREM_RESET
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        cmd_strobe,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [31:0] wr_data,
	input  wire logic        power_switch_scheme,
	input  wire logic        pwr_cmd_valid,
	input  wire logic [2:0]  pwr_cmd,
	input  wire logic [1:0]  pwr_cmd_port,
	output logic      [31:0] rd_data,
	output logic             rd_valid,
	output logic      [1:0]  port_powered_flag,
	output logic      [2:0]  non_removable_flags,
	output logic      [2:0]  per_port_power_mask
);

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	function automatic logic is_cmd(input logic [7:0] code,
	                                input logic [7:0] want);
		return code == want;
	endfunction

	logic wr_hit;
	logic rd_hit;
	assign wr_hit = cmd_strobe &&
	                is_cmd(cmd_code, rhpt_pkg::CMD_TRAITS_WR);
	assign rd_hit = cmd_strobe &&
	                is_cmd(cmd_code, rhpt_pkg::CMD_TRAITS_RD);

	// ---------------------------------------------------------------
	// Register fields
	// ---------------------------------------------------------------
	logic [2:0] mask_q;
	logic [2:0] nrem_q;

	// Bit 0 of each field is reserved and held at zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mask_q <= {MASK_INIT[2:1], 1'b0};
			nrem_q <= {NREM_INIT[2:1], 1'b0};
		end else if (wr_hit) begin
			mask_q <= {wr_data[rhpt_pkg::MASK_LSB+2],
			           wr_data[rhpt_pkg::MASK_LSB+1], 1'b0};
			nrem_q <= {wr_data[rhpt_pkg::NREM_LSB+2],
			           wr_data[rhpt_pkg::NREM_LSB+1], 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_data  <= 32'h0000_0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_hit;
			if (rd_hit)
				rd_data <= {13'h0000, mask_q, 13'h0000, nrem_q};
		end
	end

	rhpt_pwr_if pif ();

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			non_removable_flags <= 3'h0;
			per_port_power_mask <= 3'h0;
			port_powered_flag   <= 2'h0;
		end else begin
			non_removable_flags <= nrem_q;
			per_port_power_mask <= mask_q;
			port_powered_flag   <= pif.port_powered_flag;
		end
	end

	// ---------------------------------------------------------------
	// Power logic
	// ---------------------------------------------------------------
	// Mask register output drives the next command directly
	assign pif.cmd_valid           = pwr_cmd_valid;
	assign pif.cmd                 = rhpt_pkg::rhpt_pwr_cmd_e'(pwr_cmd);
	assign pif.cmd_port            = pwr_cmd_port;
	assign pif.power_switch_scheme = power_switch_scheme;
	assign pif.per_port_power_mask = mask_q;

	rhpt_port_power u_power (
		.clk  (clk),
		.rstn (rstn),
		.pif  (pif.pwr)
	);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence write_seq;
		cmd_strobe && cmd_code == rhpt_pkg::CMD_TRAITS_WR;
	endsequence

	sequence read_seq;
		cmd_strobe && cmd_code == rhpt_pkg::CMD_TRAITS_RD;
	endsequence

	write_both_a: assert property (@(posedge clk) disable iff (!rstn)
		write_seq |=> mask_q[2:1] == $past(wr_data[18:17]) &&
		              nrem_q[2:1] == $past(wr_data[2:1]))
		else $error("write did not update both fields");

	read_back_a: assert property (@(posedge clk) disable iff (!rstn)
		write_seq ##1 read_seq |=>
		rd_valid && rd_data[18:17] == $past(wr_data[18:17], 2))
		else $error("read code does not return written mask");

	reserved_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		rd_valid |-> (rd_data & 32'hFFF8_FFF8) == 32'h0000_0000 &&
		             !rd_data[16] && !rd_data[0])
		else $error("reserved bit read nonzero");

	no_write_a: assert property (@(posedge clk) disable iff (!rstn)
		!wr_hit |=> $stable(mask_q) && $stable(nrem_q))
		else $error("field changed without write command");

	removable_out_a: assert property (@(posedge clk) disable iff (!rstn)
		write_seq |-> ##2 non_removable_flags[2:1] == $past(wr_data[2:1], 2))
		else $error("non-removable flags not following write");

	// ---------------------------------------------------------------
	// Read path and field bit 0 checks
	// ---------------------------------------------------------------
	read_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
		read_seq |=> rd_valid)
		else $error("read command gave no read pulse");

	read_idle_a: assert property (@(posedge clk) disable iff (!rstn)
		!rd_hit |=> !rd_valid)
		else $error("read pulse without read command");

	read_fields_a: assert property (@(posedge clk) disable iff (!rstn)
		read_seq |=> rd_data[18:16] == $past(mask_q) &&
		             rd_data[2:0] == $past(nrem_q))
		else $error("read data does not match fields");

	read_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!rd_hit |=> $stable(rd_data))
		else $error("read data changed without read command");

	field_bit0_a: assert property (@(posedge clk) disable iff (!rstn)
		!mask_q[0] && !nrem_q[0])
		else $error("reserved field bit set");

	// ---------------------------------------------------------------
	// Output copy checks
	// ---------------------------------------------------------------
	mask_copy_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> per_port_power_mask == $past(mask_q))
		else $error("mask output lags the field");

	nrem_copy_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> non_removable_flags == $past(nrem_q))
		else $error("removability output lags the field");

	powered_copy_a: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> port_powered_flag == $past(pif.port_powered_flag))
		else $error("powered output lags the power state");

	// ---------------------------------------------------------------
	// Power command checks
	// ---------------------------------------------------------------
	sequence port_cmd_seq;
		pwr_cmd_valid &&
		(pwr_cmd == rhpt_pkg::RHPT_PWR_PORT_ON ||
		 pwr_cmd == rhpt_pkg::RHPT_PWR_PORT_OFF);
	endsequence

	sequence global_cmd_seq;
		pwr_cmd_valid &&
		(pwr_cmd == rhpt_pkg::RHPT_PWR_ALL_ON ||
		 pwr_cmd == rhpt_pkg::RHPT_PWR_ALL_OFF);
	endsequence

	// Output follows the state two edges after a command
	flag_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!pwr_cmd_valid |-> ##2 $stable(port_powered_flag))
		else $error("powered flags moved without a command");

	bad_port_a: assert property (@(posedge clk) disable iff (!rstn)
		port_cmd_seq ##0 (pwr_cmd_port == 2'h0 || pwr_cmd_port == 2'h3)
		|-> ##2 $stable(port_powered_flag))
		else $error("port command for a missing port took effect");

	ganged_port_a: assert property (@(posedge clk) disable iff (!rstn)
		port_cmd_seq ##0 !power_switch_scheme
		|-> ##2 $stable(port_powered_flag))
		else $error("port command took effect in global scheme");

	masked_global_a: assert property (@(posedge clk) disable iff (!rstn)
		global_cmd_seq ##0 (power_switch_scheme && mask_q[2])
		|-> ##2 $stable(port_powered_flag[1]))
		else $error("masked port 2 followed a global command");

endmodule

//--- dv/rhpt_traits_bench.sv
// Bench: register access and port power behaviour of the traits register
`timescale 1ns/1ps
module rhpt_traits_bench;
	localparam logic [2:0] M_INIT = 3'h7;
	localparam logic [2:0] N_INIT = 3'h5;
	logic        clk                 = 1'b0;
	logic        rstn                = 1'b0;
	logic        cmd_strobe          = 1'b0;
	logic [7:0]  cmd_code            = 8'h00;
	logic [31:0] wr_data             = 32'h0000_0000;
	logic        power_switch_scheme = 1'b0;
	logic        pwr_cmd_valid       = 1'b0;
	logic [2:0]  pwr_cmd             = 3'h0;
	logic [1:0]  pwr_cmd_port        = 2'h0;
	logic [31:0] rd_data;
	logic        rd_valid;
	logic [1:0]  port_powered_flag;
	logic [2:0]  non_removable_flags;
	logic [2:0]  per_port_power_mask;
	int          miscompares = 0;
	int          n_tests     = 0;
	int          seed        = 2;
	logic [31:0] reg_m;
	logic [1:0]  pwr_m       = 2'h0;
	logic [31:0] rnd;
	logic        rd_v;
	logic [31:0] rd_d;

	rhpt_traits #(.MASK_INIT(M_INIT), .NREM_INIT(N_INIT)) DUT (
		.clk                 (clk),
		.rstn                (rstn),
		.cmd_strobe          (cmd_strobe),
		.cmd_code            (cmd_code),
		.wr_data             (wr_data),
		.power_switch_scheme (power_switch_scheme),
		.pwr_cmd_valid       (pwr_cmd_valid),
		.pwr_cmd             (pwr_cmd),
		.pwr_cmd_port        (pwr_cmd_port),
		.rd_data             (rd_data),
		.rd_valid            (rd_valid),
		.port_powered_flag   (port_powered_flag),
		.non_removable_flags (non_removable_flags),
		.per_port_power_mask (per_port_power_mask)
	);

	always #5 clk = ~clk;

	// ---------------------------------------------------------------
	// Checking and verdict
	// ---------------------------------------------------------------
	task check(input string name, input logic [31:0] seen,
	           input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Power state expected after one command
	function logic [1:0] exp_pwr(logic [1:0] pw, logic sch, logic [2:0] m,
		logic [2:0] c, logic [1:0] p);
		logic [1:0] sel;
		logic       on;
		sel = 2'b00;
		on  = (c == 3'h1) || (c == 3'h3);
		if (c == 3'h1 || c == 3'h2)
			sel = sch ? ~m[2:1] : 2'b11;
		else if ((c == 3'h3 || c == 3'h4) && sch && (p == 2'd1 || p == 2'd2))
			sel = m[2:1] & ((p == 2'd1) ? 2'b01 : 2'b10);
		return on ? (pw | sel) : (pw & ~sel);
	endfunction

	// ---------------------------------------------------------------
	// Bus and power command drivers
	// ---------------------------------------------------------------
	task bus(input logic [7:0] code, input logic [31:0] data);
		@(negedge clk);
		cmd_strobe = 1'b1;
		cmd_code   = code;
		wr_data    = data;
		@(negedge clk);
		rd_v       = rd_valid;
		rd_d       = rd_data;
		cmd_strobe = 1'b0;
		wr_data    = ~data;
		@(negedge clk);
	endtask

	// Write then read on the very next edge; the read sees the new fields
	task wr_then_rd(input logic [31:0] data);
		@(negedge clk);
		cmd_strobe = 1'b1;
		cmd_code   = rhpt_pkg::CMD_TRAITS_WR;
		wr_data    = data;
		reg_m      = data & 32'h0006_0006;
		@(negedge clk);
		cmd_code   = rhpt_pkg::CMD_TRAITS_RD;
		wr_data    = ~data;
		@(negedge clk);
		cmd_strobe = 1'b0;
		check("b2b valid", {31'h0, rd_valid}, 32'h0000_0001);
		check("b2b data", rd_data, reg_m);
		@(negedge clk);
	endtask

	task rd_check;
		bus(rhpt_pkg::CMD_TRAITS_RD, 32'h0000_0000);
		check("rd_valid", {31'h0, rd_v}, 32'h0000_0001);
		check("rd_data", rd_d, reg_m);
		@(negedge clk);
		check("rd_valid low", {31'h0, rd_valid}, 32'h0000_0000);
	endtask

	task wr(input logic [7:0] code, input logic [31:0] data);
		bus(code, data);
		if (code == rhpt_pkg::CMD_TRAITS_WR)
			reg_m = data & 32'h0006_0006;
		@(negedge clk);
		check("mask", {29'h0, per_port_power_mask}, reg_m[18:16]);
		check("nrem", {29'h0, non_removable_flags}, reg_m[2:0]);
	endtask

	task pwr(input logic sch, input logic [2:0] c, input logic [1:0] p);
		@(negedge clk);
		power_switch_scheme = sch;
		pwr_cmd_valid       = 1'b1;
		pwr_cmd             = c;
		pwr_cmd_port        = p;
		pwr_m = exp_pwr(pwr_m, sch, reg_m[18:16], c, p);
		@(negedge clk);
		pwr_cmd_valid = 1'b0;
		repeat (2) @(negedge clk);
		check("pwr", {30'h0, port_powered_flag}, 32'(pwr_m));
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		reg_m = {13'h0, M_INIT & 3'h6, 13'h0, N_INIT & 3'h6};
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		check("mask rst", {29'h0, per_port_power_mask}, reg_m[18:16]);
		check("nrem rst", {29'h0, non_removable_flags}, reg_m[2:0]);
		check("pwr rst", {30'h0, port_powered_flag}, 32'h0000_0000);
		rd_check();
		wr(rhpt_pkg::CMD_TRAITS_WR, 32'hFFFF_FFFF);
		rd_check();
		wr(8'h94, 32'h0000_0000);
		rd_check();
		pwr(1'b1, 3'h1, 2'd0);
		pwr(1'b1, 3'h3, 2'd1);
		wr(rhpt_pkg::CMD_TRAITS_WR, 32'h0000_0000);
		pwr(1'b1, 3'h1, 2'd0);
		pwr(1'b0, 3'h2, 2'd0);
		for (int i = 0; i < 150; i++) begin
			rnd = $random(seed);
			if (rnd[3:0] < 4'd3) begin
				wr(rhpt_pkg::CMD_TRAITS_WR, $random(seed));
				rd_check();
			end else if (rnd[3:0] == 4'd3) begin
				wr({rnd[31:25], 1'b0}, $random(seed));
			end else if (rnd[3:0] == 4'd4) begin
				wr_then_rd($random(seed));
			end else
				pwr(rnd[4], 3'(rnd[7:5] % 5), rnd[9:8]);
		end
		print_verdict();
	end

	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end
endmodule
